//--- bbar_top.sv
// Bit-band alias remapper between the processor data bus and SRAM/peripheral memory.
// Assumes a host that holds its request until the done pulse and a memory that
// completes an access in the cycle it raises ready, with lane-placed data.
//
// Overview of operation
// - Bit-band windows are each region's lowest megabyte.
// - SRAM alias words map to SRAM bit-band bits.
// - Peripheral alias words map to peripheral bit-band bits.
// - Memory access keeps the alias access size.
// - Direct SRAM accesses pass as plain SRAM.
// - Alias writes become read, modify, write back.
// - SRAM alias remaps data; fetches pass unchanged.
// - Direct peripheral accesses pass as plain peripheral.
// - Peripheral alias remaps data; fetches refused.
// - Alias offset is byte times 32 plus bit times 4.
// - Bit number 0 to 7 from alias address.
// - Written bit 0 sets or clears target bit.
// - Upper written alias bits are ignored.
// - Alias read returns zero or one.
// - Little-endian storage; bit lane follows byte address.
`timescale 1ns/10ps
`default_nettype none
module bbar_top
    import bbar_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Host request, held until the done pulse.
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_instr_in,
    input wire logic [1:0] req_size_in,
    input wire logic [31:0] req_addr_in,
    input wire logic [31:0] req_wdata_in,
    // Host answer.
    output logic host_done_out,
    output logic host_err_out,
    output logic [31:0] host_rdata_out,
    // Memory request.
    output logic mem_valid_out,
    output logic mem_write_out,
    output logic [1:0] mem_size_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    // Memory answer.
    input wire logic mem_ready_in,
    input wire logic [31:0] mem_rdata_in
);

    typedef struct packed {
        bbar_state_t state;
        logic mem_valid;
        logic mem_write;
        logic [1:0] mem_size;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic done;
        logic err;
        logic [31:0] rdata;
        logic alias_wr;
        logic wbit;
        logic [4:0] lane_bit;
    } bbar_regs_t;

    bbar_regs_t s;
    bbar_regs_t next_s;
    bbar_map_if map ();

    // Replaces one bit of a lane-placed word, keeping all others.
    function automatic logic [31:0] put_bit(input logic [31:0] w, input logic [4:0] idx, input logic v);
        logic [31:0] r;
        r = w;
        r[idx] = v;
        put_bit = r;
    endfunction

    // The decoder looks straight at the held request; it is only used in the idle state.
    assign map.addr = req_addr_in;
    assign map.instr = req_instr_in;
    assign map.size = req_size_in;

    bbar_decode u_decode (
        .map(map)
    );

    // Next-state logic. Only one access is in flight, which keeps the
    // read-modify-write atomic from the host's view at the cost of throughput.
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.err = 1'b0;
        unique case (s.state)
            BBAR_IDLE: begin
                if (req_valid_in) begin
                    next_s.mem_size = req_size_in;
                    next_s.mem_addr = map.mem_addr;
                    next_s.lane_bit = map.lane_bit;
                    next_s.wbit = req_wdata_in[0];
                    next_s.alias_wr = 1'b0;
                    if (map.refused) begin
                        next_s.done = 1'b1;
                        next_s.err = 1'b1;
                        next_s.rdata = BBAR_ALIAS_CLEAR;
                        next_s.state = BBAR_RESP;
                    end else if (map.sram_alias || map.peri_alias) begin
                        // Alias access always starts with a read of the bit-band location.
                        next_s.mem_valid = 1'b1;
                        next_s.mem_write = 1'b0;
                        next_s.mem_wdata = 32'h0000_0000;
                        next_s.alias_wr = req_write_in;
                        next_s.state = BBAR_ARD;
                    end else begin
                        // Direct SRAM, peripheral and all other addresses go out untouched.
                        next_s.mem_valid = 1'b1;
                        next_s.mem_write = req_write_in;
                        next_s.mem_wdata = req_wdata_in;
                        next_s.state = BBAR_PASS;
                    end
                end
            end
            BBAR_PASS: begin
                if (mem_ready_in) begin
                    next_s.mem_valid = 1'b0;
                    next_s.mem_write = 1'b0;
                    next_s.rdata = s.mem_write ? 32'h0000_0000 : mem_rdata_in;
                    next_s.done = 1'b1;
                    next_s.state = BBAR_RESP;
                end
            end
            BBAR_ARD: begin
                if (mem_ready_in) begin
                    if (s.alias_wr) begin
                        // Write back the read word with only the target bit changed.
                        next_s.mem_write = 1'b1;
                        next_s.mem_wdata = put_bit(mem_rdata_in, s.lane_bit, s.wbit);
                        next_s.state = BBAR_AWR;
                    end else begin
                        next_s.mem_valid = 1'b0;
                        next_s.rdata = mem_rdata_in[s.lane_bit] ? BBAR_ALIAS_SET : BBAR_ALIAS_CLEAR;
                        next_s.done = 1'b1;
                        next_s.state = BBAR_RESP;
                    end
                end
            end
            BBAR_AWR: begin
                if (mem_ready_in) begin
                    next_s.mem_valid = 1'b0;
                    next_s.mem_write = 1'b0;
                    next_s.rdata = 32'h0000_0000;
                    next_s.done = 1'b1;
                    next_s.state = BBAR_RESP;
                end
            end
            BBAR_RESP: begin
                // One idle cycle lets the host retire its request before the next is sampled.
                next_s.state = BBAR_IDLE;
            end
            default: begin
                next_s = '0;
                next_s.state = BBAR_IDLE;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= '0;
            s.state <= BBAR_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Every output is a flip-flop of the state.
    assign host_done_out = s.done;
    assign host_err_out = s.err;
    assign host_rdata_out = s.rdata;
    assign mem_valid_out = s.mem_valid;
    assign mem_write_out = s.mem_write;
    assign mem_size_out = s.mem_size;
    assign mem_addr_out = s.mem_addr;
    assign mem_wdata_out = s.mem_wdata;

    // Helper flags for the checks below.
    // They decode the windows afresh from the raw request, so a decoder slip cannot hide itself.
    logic take;
    logic take_sram_data;
    logic take_peri_data;
    logic take_direct;
    assign take = (s.state == BBAR_IDLE) && req_valid_in;
    assign take_sram_data = take && req_addr_in[31:25] == BBAR_SRAM_ALIAS_BASE[31:25] && !req_instr_in;
    assign take_peri_data = take && req_addr_in[31:25] == BBAR_PERI_ALIAS_BASE[31:25] && !req_instr_in;
    assign take_direct = take && req_addr_in[31:25] != BBAR_SRAM_ALIAS_BASE[31:25]
        && req_addr_in[31:25] != BBAR_PERI_ALIAS_BASE[31:25];

    // SRAM alias data lands in the lowest megabyte of SRAM.
    chk_sram_bb_map: assert property (@(posedge clk_in) disable iff (reset_in)
        take_sram_data |=> mem_valid_out && mem_addr_out[31:20] == BBAR_SRAM_BB_BASE[31:20])
        else $error("SRAM alias not mapped into SRAM bit-band window");

    // Peripheral alias data lands in the lowest megabyte of the peripheral region.
    chk_peri_bb_map: assert property (@(posedge clk_in) disable iff (reset_in)
        take_peri_data |=> mem_valid_out && mem_addr_out[31:20] == BBAR_PERI_BB_BASE[31:20])
        else $error("Peripheral alias not mapped into peripheral bit-band window");

    // Byte offset and bit number come from the alias address.
    chk_offset_math: assert property (@(posedge clk_in) disable iff (reset_in)
        (take_sram_data || take_peri_data) |=>
            mem_addr_out[19:2] == $past(req_addr_in[24:7]) && s.lane_bit == $past(req_addr_in[6:2]))
        else $error("Alias offset arithmetic wrong");

    // Memory access keeps the request size.
    chk_size_kept: assert property (@(posedge clk_in) disable iff (reset_in)
        take |=> mem_size_out == $past(req_size_in) || host_err_out)
        else $error("Access size not preserved");

    // Direct accesses go out unchanged.
    chk_direct_pass: assert property (@(posedge clk_in) disable iff (reset_in)
        take_direct |=> mem_addr_out == $past(req_addr_in) && mem_write_out == $past(req_write_in)
            && mem_wdata_out == $past(req_wdata_in))
        else $error("Direct access altered");

    // SRAM alias fetches are not remapped.
    chk_fetch_pass: assert property (@(posedge clk_in) disable iff (reset_in)
        take && req_instr_in && req_addr_in[31:25] == BBAR_SRAM_ALIAS_BASE[31:25]
            |=> mem_valid_out && mem_addr_out == $past(req_addr_in))
        else $error("SRAM alias fetch was remapped");

    // Peripheral alias fetches are refused without a memory access.
    chk_fetch_refused: assert property (@(posedge clk_in) disable iff (reset_in)
        take && req_instr_in && req_addr_in[31:25] == BBAR_PERI_ALIAS_BASE[31:25]
            |=> host_done_out && host_err_out && !mem_valid_out)
        else $error("Peripheral alias fetch not refused");

    // An alias write reads first, then writes back the same address.
    chk_rmw_order: assert property (@(posedge clk_in) disable iff (reset_in)
        (s.state == BBAR_ARD) && s.alias_wr && mem_ready_in |=>
            mem_valid_out && mem_write_out && $stable(mem_addr_out) ##[1:1000] host_done_out)
        else $error("Alias write not read-modify-write");

    // The write-back carries written bit 0 in the target lane, other bits as read.
    chk_write_bit: assert property (@(posedge clk_in) disable iff (reset_in)
        (s.state == BBAR_ARD) && s.alias_wr && mem_ready_in |=>
            mem_wdata_out[s.lane_bit] == s.wbit
            && ((mem_wdata_out ^ $past(mem_rdata_in)) == (32'h0000_0001 << s.lane_bit)
                || mem_wdata_out == $past(mem_rdata_in)))
        else $error("Write-back data wrong");

    // Alias reads answer zero or one, matching the target bit.
    chk_read_value: assert property (@(posedge clk_in) disable iff (reset_in)
        (s.state == BBAR_ARD) && !s.alias_wr && mem_ready_in |=>
            host_done_out && host_rdata_out == {31'h0000_0000, $past(mem_rdata_in[s.lane_bit])})
        else $error("Alias read value wrong");

    // The host sees no done while memory work is outstanding.
    chk_stall_host: assert property (@(posedge clk_in) disable iff (reset_in)
        mem_valid_out |-> !host_done_out)
        else $error("Done raised during memory access");

    // A stalled memory request keeps every qualifier until memory answers.
    chk_mem_hold: assert property (@(posedge clk_in) disable iff (reset_in)
        mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_addr_out) && $stable(mem_write_out)
            && $stable(mem_wdata_out) && $stable(mem_size_out))
        else $error("Memory request changed before ready");

    // Done is a single-cycle pulse, followed by the quiet turnaround cycle.
    chk_done_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
        host_done_out |=> !host_done_out && !mem_valid_out)
        else $error("Done held longer than one cycle");

    // An error is only ever reported together with done and a zero answer.
    chk_err_with_done: assert property (@(posedge clk_in) disable iff (reset_in)
        host_err_out |-> host_done_out && host_rdata_out == BBAR_ALIAS_CLEAR)
        else $error("Error raised without done");

    // Any alias data access opens with a read, whatever the host asked for.
    chk_alias_read_first: assert property (@(posedge clk_in) disable iff (reset_in)
        (take_sram_data || take_peri_data) |=> mem_valid_out && !mem_write_out)
        else $error("Alias access did not start with a read");

    // Word and halfword alias accesses reach memory naturally aligned.
    chk_alias_aligned: assert property (@(posedge clk_in) disable iff (reset_in)
        (take_sram_data || take_peri_data) && (req_size_in == BBAR_SIZE_WORD || req_size_in == BBAR_SIZE_HALF) |=>
            mem_addr_out[0] == 1'b0 && (mem_size_out != BBAR_SIZE_WORD || mem_addr_out[1] == 1'b0))
        else $error("Alias memory address not aligned to size");

    // The bit to write comes from bit 0 of the host data alone.
    chk_wbit_lsb: assert property (@(posedge clk_in) disable iff (reset_in)
        (take_sram_data || take_peri_data) && req_write_in |=> s.alias_wr && s.wbit == $past(req_wdata_in[0]))
        else $error("Alias write bit not taken from bit 0");

    // Main scenarios.
    cov_alias_write: cover property (@(posedge clk_in) disable iff (reset_in)
        (s.state == BBAR_AWR) && mem_ready_in);
    cov_alias_read: cover property (@(posedge clk_in) disable iff (reset_in)
        (s.state == BBAR_ARD) && !s.alias_wr && mem_ready_in);
    cov_refused: cover property (@(posedge clk_in) disable iff (reset_in)
        host_done_out && host_err_out);
    cov_direct: cover property (@(posedge clk_in) disable iff (reset_in)
        (s.state == BBAR_PASS) && mem_ready_in);
    cov_byte_alias: cover property (@(posedge clk_in) disable iff (reset_in)
        take_sram_data && req_write_in && req_size_in == BBAR_SIZE_BYTE);

endmodule
`default_nettype wire

//--- bbar_pkg.sv
// Package for the bit-band alias remapper: address map, field positions,
// access size codes and the controller state type.
// Assumes a 32-bit byte-addressed data bus with little-endian byte lanes.
package bbar_pkg;

    // Bit-band windows sit in the lowest megabyte of each region.
    localparam logic [31:0] BBAR_SRAM_BB_BASE = 32'h2000_0000;
    localparam logic [31:0] BBAR_PERI_BB_BASE = 32'h4000_0000;
    // Alias windows, each 32 MB, one word per bit-band bit.
    localparam logic [31:0] BBAR_SRAM_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] BBAR_PERI_ALIAS_BASE = 32'h4200_0000;
    // Populated direct and alias ranges, kept for reference by users of the map.
    localparam logic [31:0] BBAR_SRAM_DIRECT_END = 32'h2000_1FFF;
    localparam logic [31:0] BBAR_PERI_DIRECT_END = 32'h400F_FFFF;
    localparam logic [31:0] BBAR_SRAM_ALIAS_USED_END = 32'h2203_FFFF;
    localparam logic [31:0] BBAR_PERI_ALIAS_END = 32'h43FF_FFFF;

    // Field positions inside an alias address.
    localparam int BBAR_ALIAS_SPAN_BITS = 25;
    localparam int BBAR_BB_SPAN_BITS = 20;
    localparam int BBAR_BIT_NUM_LSB = 2;
    localparam int BBAR_BYTE_OFS_LSB = 5;
    localparam int BBAR_BIT_NUM_W = 3;

    // Access size codes, shared by host and memory sides.
    localparam logic [1:0] BBAR_SIZE_BYTE = 2'h0;
    localparam logic [1:0] BBAR_SIZE_HALF = 2'h1;
    localparam logic [1:0] BBAR_SIZE_WORD = 2'h2;

    // Read answers of an alias word.
    localparam logic [31:0] BBAR_ALIAS_CLEAR = 32'h0000_0000;
    localparam logic [31:0] BBAR_ALIAS_SET = 32'h0000_0001;

    // Controller states, one-hot.
    typedef enum logic [4:0] {
        BBAR_IDLE = 5'h01,
        BBAR_PASS = 5'h02,
        BBAR_ARD = 5'h04,
        BBAR_AWR = 5'h08,
        BBAR_RESP = 5'h10
    } bbar_state_t;

endpackage

//--- bbar_map_if.sv
// Interface carrying one request address to the alias decoder and its verdict back.
// Assumes both ends sit in the same clock domain; the decoder is purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface bbar_map_if;
    logic [31:0] addr;
    logic instr;
    logic [1:0] size;
    logic sram_alias;
    logic peri_alias;
    logic refused;
    logic [31:0] mem_addr;
    logic [4:0] lane_bit;

    modport dec (
        input addr, instr, size,
        output sram_alias, peri_alias, refused, mem_addr, lane_bit
    );
    modport user (
        output addr, instr, size,
        input sram_alias, peri_alias, refused, mem_addr, lane_bit
    );
endinterface
`default_nettype wire

//--- bbar_decode.sv
// Alias address decoder: finds alias hits and computes the bit-band address and bit lane.
// Assumes the caller holds addr, instr and size stable while it samples the results.
`timescale 1ns/10ps
`default_nettype none
module bbar_decode
    import bbar_pkg::*;
(
    // Decode request and result.
    bbar_map_if.dec map
);

    // True when an address lies in the 32 MB alias window starting at base.
    function automatic logic alias_hit(input logic [31:0] a, input logic [31:0] base);
        alias_hit = (a[31:BBAR_ALIAS_SPAN_BITS] == base[31:BBAR_ALIAS_SPAN_BITS]);
    endfunction

    // Aligns a byte address down to the natural boundary of the access size.
    function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
        unique case (sz)
            BBAR_SIZE_WORD: align = {a[31:2], 2'h0};
            BBAR_SIZE_HALF: align = {a[31:1], 1'h0};
            default: align = a;
        endcase
    endfunction

    logic hit_sram;
    logic hit_peri;
    logic [31:0] bb_byte;
    logic [BBAR_BB_SPAN_BITS-1:0] byte_ofs;
    logic [BBAR_BIT_NUM_W-1:0] bit_num;

    // Alias word offset is byte offset times 32 plus bit number times 4.
    assign byte_ofs = map.addr[BBAR_ALIAS_SPAN_BITS-1:BBAR_BYTE_OFS_LSB];
    assign bit_num = map.addr[BBAR_BYTE_OFS_LSB-1:BBAR_BIT_NUM_LSB];
    assign hit_sram = alias_hit(map.addr, BBAR_SRAM_ALIAS_BASE);
    assign hit_peri = alias_hit(map.addr, BBAR_PERI_ALIAS_BASE);

    // Each region's bit-band window is its lowest megabyte.
    assign bb_byte = (hit_sram ? BBAR_SRAM_BB_BASE : BBAR_PERI_BB_BASE) | {12'h000, byte_ofs};

    // Fetches in the SRAM alias pass unchanged; fetches in the peripheral alias are refused.
    assign map.sram_alias = hit_sram && !map.instr;
    assign map.peri_alias = hit_peri && !map.instr;
    assign map.refused = hit_peri && map.instr;

    // Alias data goes to the bit-band byte at the same access size, unchanged otherwise.
    assign map.mem_addr = (map.sram_alias || map.peri_alias) ? align(bb_byte, map.size) : map.addr;

    // Little-endian lanes: the byte's low address bits pick the lane of the 32-bit bus.
    assign map.lane_bit = {bb_byte[1:0], bit_num};

endmodule
`default_nettype wire

//--- bbar_mem_model.sv
// Behavioural memory behind the remapper: sparse byte store with lane-placed data.
// Assumes one outstanding request that the remapper holds until ready.
`timescale 1ns/10ps
`default_nettype none
module bbar_mem_model
    import bbar_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Request from the remapper.
    input wire logic mem_valid_in,
    input wire logic mem_write_in,
    input wire logic [1:0] mem_size_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [31:0] mem_wdata_in,
    // Answer and stall length.
    input wire logic [3:0] wait_in,
    output logic mem_ready_out,
    output logic [31:0] mem_rdata_out,
    // Record of the last completed access.
    output int acc_count_out,
    output logic [31:0] last_addr_out,
    output logic [1:0] last_size_out
);
    logic [7:0] store [logic [31:0]];
    logic [3:0] wait_cnt;
    logic [31:0] prev_rdata;
    logic [31:0] base;

    // Unwritten bytes read as a fixed pattern so that expectations stay defined.
    function automatic logic [7:0] peek(input logic [31:0] a);
        return store.exists(a) ? store[a] : 8'hA5;
    endfunction

    // Ready comes after the chosen number of stall cycles.
    assign base = {mem_addr_in[31:2], 2'h0};
    assign mem_ready_out = mem_valid_in && (wait_cnt >= wait_in);

    // Outside the ready cycle the data lines show the inverse of the last answer, so a stale capture shows.
    always @* begin
        if (mem_ready_out) begin
            mem_rdata_out = {peek(base + 32'h3), peek(base + 32'h2), peek(base + 32'h1), peek(base)};
        end else begin
            mem_rdata_out = ~prev_rdata;
        end
    end

    // Count stalls, record each completed access and store the written lanes.
    always @(posedge clk_in) begin
        if (reset_in) begin
            wait_cnt <= 4'h0;
            acc_count_out <= 0;
            prev_rdata <= 32'h0;
        end else if (mem_ready_out) begin
            wait_cnt <= 4'h0;
            acc_count_out <= acc_count_out + 1;
            last_addr_out <= mem_addr_in;
            last_size_out <= mem_size_in;
            prev_rdata <= mem_rdata_out;
            if (mem_write_in) begin
                for (int i = 0; i < 4; i++) begin
                    if (mem_size_in == BBAR_SIZE_WORD || (mem_size_in == BBAR_SIZE_HALF && i[1] == mem_addr_in[1])
                        || i[1:0] == mem_addr_in[1:0]) begin
                        store[base + 32'(i)] = mem_wdata_in[8*i +: 8];
                    end
                end
            end
        end else if (mem_valid_in) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- bbar_top_tb.sv
// Self-checking bench for the remapper: tasks act as the host, a memory model answers.
// Assumes the host handshake of the top module and a memory that may stall.
`timescale 1ns/10ps
`default_nettype none
module bbar_top_tb
    import bbar_pkg::*;
    ;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic req_instr_in = 1'b0;
    logic [1:0] req_size_in = 2'h0;
    logic [31:0] req_addr_in = 32'h0;
    logic [31:0] req_wdata_in = 32'h0;
    logic host_done_out, host_err_out, mem_valid_out, mem_write_out, mem_ready_in;
    logic [31:0] host_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in, last_addr, got_data;
    logic [1:0] mem_size_out, last_size;
    logic [3:0] mem_wait = 4'h0;
    logic got_err;
    int acc_count, c0, err_total = 0, n_compared = 0;

    bbar_top u_bbar_top (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_instr_in(req_instr_in), .req_size_in(req_size_in),
        .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .host_done_out(host_done_out),
        .host_err_out(host_err_out), .host_rdata_out(host_rdata_out), .mem_valid_out(mem_valid_out),
        .mem_write_out(mem_write_out), .mem_size_out(mem_size_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_ready_in(mem_ready_in), .mem_rdata_in(mem_rdata_in));

    bbar_mem_model u_bbar_mem_model (.clk_in(clk_in), .reset_in(reset_in), .mem_valid_in(mem_valid_out),
        .mem_write_in(mem_write_out), .mem_size_in(mem_size_out), .mem_addr_in(mem_addr_out),
        .mem_wdata_in(mem_wdata_out), .wait_in(mem_wait), .mem_ready_out(mem_ready_in),
        .mem_rdata_out(mem_rdata_in), .acc_count_out(acc_count), .last_addr_out(last_addr),
        .last_size_out(last_size));

    // Free-running 100 MHz clock.
    always #5 clk_in = ~clk_in;

    task automatic tally_and_finish();
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    // One host transfer; the request is held until done is seen, then dropped.
    task automatic access(input logic wr, input logic ins, input logic [1:0] sz, input logic [31:0] a,
        input logic [31:0] wd);
        int n;
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_instr_in = ins;
        req_size_in = sz;
        req_addr_in = a;
        req_wdata_in = wd;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (host_done_out !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_total++;
        end
        got_data = host_rdata_out;
        got_err = host_err_out;
        req_valid_in = 1'b0;
    endtask

    // Alias word address worked out independently of the design.
    function automatic logic [31:0] alias_of(input logic [31:0] win, input logic [31:0] byte_addr, input int b);
        return win + ((byte_addr & 32'h000F_FFFF) << 5) + 32'(b * 4);
    endfunction

    task automatic t_direct_sram();
        access(1'b1, 1'b0, BBAR_SIZE_WORD, 32'h2000_0100, 32'h8765_4321);
        access(1'b0, 1'b0, BBAR_SIZE_BYTE, 32'h2000_0101, 32'h0);
        check(got_data[15:8], 32'h43);
        check(last_addr, 32'h2000_0101);
        check(last_size, BBAR_SIZE_BYTE);
    endtask

    task automatic t_alias_read_sram();
        for (int b = 0; b < 8; b++) begin
            access(1'b0, 1'b0, BBAR_SIZE_WORD, alias_of(BBAR_SRAM_ALIAS_BASE, 32'h2000_0101, b), 32'h0);
            check(got_data, (32'h43 >> b) & 32'h1);
            check(last_addr, 32'h2000_0100);
        end
        // Top of the window: byte 0x200F_FFFF still holds the unwritten pattern.
        access(1'b0, 1'b0, BBAR_SIZE_WORD, 32'h23FF_FFE0, 32'h0);
        check(got_data, 32'h1);
        check(last_addr, 32'h200F_FFFC);
    endtask

    // Memory stalls two cycles per access while the bits are modified.
    task automatic t_alias_write_sram();
        mem_wait = 4'h2;
        c0 = acc_count;
        access(1'b1, 1'b0, BBAR_SIZE_WORD, alias_of(BBAR_SRAM_ALIAS_BASE, 32'h2000_0101, 0), 32'hFFFF_FFFE);
        check(32'(acc_count - c0), 32'h2);
        check(got_data, 32'h0);
        access(1'b1, 1'b0, BBAR_SIZE_WORD, alias_of(BBAR_SRAM_ALIAS_BASE, 32'h2000_0101, 7), 32'h1);
        access(1'b1, 1'b0, BBAR_SIZE_WORD, alias_of(BBAR_SRAM_ALIAS_BASE, 32'h2000_0101, 1), 32'hE);
        access(1'b1, 1'b0, BBAR_SIZE_BYTE, alias_of(BBAR_SRAM_ALIAS_BASE, 32'h2000_0101, 2), 32'hFF);
        check(last_addr, 32'h2000_0101);
        check(last_size, BBAR_SIZE_BYTE);
        access(1'b0, 1'b0, BBAR_SIZE_WORD, 32'h2000_0100, 32'h0);
        check(got_data, 32'h8765_C421);
        mem_wait = 4'h0;
    endtask

    task automatic t_periph();
        mem_wait = 4'h1;
        access(1'b1, 1'b0, BBAR_SIZE_WORD, 32'h4000_0004, 32'h0000_0800);
        access(1'b0, 1'b0, BBAR_SIZE_HALF, alias_of(BBAR_PERI_ALIAS_BASE, 32'h4000_0005, 3), 32'h0);
        check(got_data, 32'h1);
        check(last_addr, 32'h4000_0004);
        check(last_size, BBAR_SIZE_HALF);
        access(1'b1, 1'b0, BBAR_SIZE_HALF, alias_of(BBAR_PERI_ALIAS_BASE, 32'h4000_0005, 3), 32'h2);
        access(1'b0, 1'b0, BBAR_SIZE_WORD, 32'h4000_0004, 32'h0);
        check(got_data, 32'h0);
        access(1'b0, 1'b0, BBAR_SIZE_WORD, 32'h43FF_FFFC, 32'h0);
        check(last_addr, 32'h400F_FFFC);
        mem_wait = 4'h0;
    endtask

    task automatic t_fetch_and_outside();
        c0 = acc_count;
        access(1'b0, 1'b1, BBAR_SIZE_WORD, 32'h4200_0040, 32'h0);
        check(got_err, 1'b1);
        check(32'(acc_count - c0), 32'h0);
        access(1'b0, 1'b1, BBAR_SIZE_WORD, 32'h2200_0040, 32'h0);
        check(got_err, 1'b0);
        check(last_addr, 32'h2200_0040);
        check(got_data, 32'hA5A5_A5A5);
        access(1'b1, 1'b0, BBAR_SIZE_WORD, 32'h6000_0010, 32'h1234_5678);
        access(1'b0, 1'b0, BBAR_SIZE_WORD, 32'h6000_0010, 32'h0);
        check(got_data, 32'h1234_5678);
        check(last_addr, 32'h6000_0010);
    endtask

    // Cuts a hang short; the whole run needs far fewer cycles.
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    // Reset for 20 cycles, outputs checked quiet, then each scenario.
    initial begin
        repeat (20) @(posedge clk_in);
        #1;
        check({host_done_out, host_err_out, mem_valid_out, mem_write_out}, 32'h0);
        reset_in = 1'b0;
        t_direct_sram();
        t_alias_read_sram();
        t_alias_write_sram();
        t_periph();
        t_fetch_and_outside();
        tally_and_finish();
    end
endmodule
`default_nettype wire
